/* logic/cmd_port_pkg.sv */
package cmd_port_pkg;

  // Widths of the user-facing buses.
  localparam int INJ_W       = 40;
  localparam int BYTE_W      = 8;
  localparam int ADDR_W      = 32;

  // Cycles that one injection keeps the injection indication high.
  localparam logic [3:0] INJ_BUSY_CYC = 4'h8;

  // Fetch command byte codes: first byte says what kind of frame is wanted.
  localparam logic [7:0] FETCH_CFG_FRAME = 8'h01;
  localparam logic [7:0] FETCH_ESS_FRAME = 8'h02;

  // Number of command bytes per fetch: kind, then four address bytes.
  localparam logic [2:0] FETCH_CMD_LEN = 3'h5;

  // Number of reply bytes absorbed for one fetch.
  localparam logic [7:0] FETCH_RX_LEN = 8'h04;

  // ASCII characters used on the console channel.
  localparam logic [7:0] ASC_CR   = 8'h0D;
  localparam logic [7:0] ASC_I    = 8'h49;
  localparam logic [7:0] ASC_O    = 8'h4F;
  localparam logic [7:0] ASC_C    = 8'h43;
  localparam logic [7:0] ASC_Q    = 8'h3F;

  // Controller activity.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_INJECT  = 3'b001,
    ST_FETCH_TX = 3'b010,
    ST_FETCH_RX = 3'b011
  } ctl_state_e;

endpackage

/* logic/cmd_ports.sv */
module cmd_ports
  import cmd_port_pkg::*;
(
  // Clock and synchronous reset.
  input  wire logic                            clk,
  input  wire logic                            rst,
  // Injection request from user logic.
  input  wire logic                            inject_req,
  input  wire logic [cmd_port_pkg::INJ_W-1:0]  inject_param,
  // Fetch trigger from the correction or classification engine.
  input  wire logic                            fetch_req,
  input  wire logic                            fetch_essential,
  input  wire logic                            status_correct,
  input  wire logic                            status_classify,
  // Other state indications of the controller.
  input  wire logic                            status_init,
  input  wire logic                            status_observe,
  // Console channel pair towards the serial console bridge.
  output logic      [cmd_port_pkg::BYTE_W-1:0] mon_tx_data,
  output logic                                 mon_tx_write,
  input  wire logic                            mon_tx_full,
  input  wire logic [cmd_port_pkg::BYTE_W-1:0] mon_rx_data,
  output logic                                 mon_rx_read,
  input  wire logic                            mon_rx_empty,
  // Fetch channel pair towards the external source.
  output logic      [cmd_port_pkg::BYTE_W-1:0] fetch_tx_data,
  output logic                                 fetch_tx_write,
  input  wire logic                            fetch_tx_full,
  input  wire logic [cmd_port_pkg::BYTE_W-1:0] fetch_rx_data,
  output logic                                 fetch_rx_read,
  input  wire logic                            fetch_rx_empty,
  input  wire logic [cmd_port_pkg::ADDR_W-1:0] fetch_table_base,
  // Results.
  output logic                                 inject_busy,
  output logic                                 flip_strobe,
  output logic      [cmd_port_pkg::INJ_W-1:0]  flip_param,
  output logic                                 ctl_idle,
  output logic      [cmd_port_pkg::ADDR_W-1:0] fetch_word
);
  import cmd_port_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State record.

  // All registered state of the block.
  typedef struct packed {
    ctl_state_e                st;          // Controller activity.
    logic [3:0]                inj_cnt;     // Injection busy countdown.
    logic [INJ_W-1:0]          param;       // Captured injection parameter.
    logic                      flip;        // One-cycle bit-flip command.
    logic                      busy;        // Injection in progress.
    logic                      idle;        // Registered idle indication.
    logic [2:0]                tx_idx;      // Fetch command byte index.
    logic [7:0]                rx_cnt;      // Fetch reply bytes still due.
    logic [ADDR_W-1:0]         rx_word;     // Assembled reply word.
    logic [1:0]                bvld;        // Console buffer entry valid.
    logic [BYTE_W-1:0]         b0;          // Console buffer entry 0 (head).
    logic [BYTE_W-1:0]         b1;          // Console buffer entry 1.
    logic [BYTE_W-1:0]         mtx;         // Console transmit byte.
    logic                      mwr;         // Console write strobe.
    logic                      mrd;         // Console read strobe.
    logic [BYTE_W-1:0]         ftx;         // Fetch transmit byte.
    logic                      fwr;         // Fetch write strobe.
    logic                      frd;         // Fetch read strobe.
  } ctl_s;

  ctl_s s_r;    // Registered state.
  ctl_s s_nxt;  // Next state.

  // Console buffer handshake terms.
  logic buf_in_valid;   // A received byte is offered to the buffer.
  logic buf_in_ready;   // Buffer has room.
  logic buf_out_valid;  // Buffer holds a byte to echo.
  logic buf_out_ready;  // Transmit side can take a byte this cycle.
  logic [BYTE_W-1:0] echo_byte;  // Byte to send back on the console.

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Computes the whole next state from the present state and the inputs.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.flip = 1'b0;
    s_nxt.mwr  = 1'b0;
    s_nxt.mrd  = 1'b0;
    s_nxt.fwr  = 1'b0;
    s_nxt.frd  = 1'b0;

    // Console buffer: a byte is read only when the bridge shows data.
    buf_in_valid  = !mon_rx_empty && !s_r.mrd;
    buf_in_ready  = !s_r.bvld[1];
    buf_out_valid = s_r.bvld[0];
    buf_out_ready = !mon_tx_full && !s_r.mwr;
    // Carriage return is answered with a one-letter state report.
    if (s_r.b0 == ASC_CR) begin
      echo_byte = s_r.busy ? ASC_I : (s_r.idle ? ASC_O : ASC_C);
    end else if (s_r.b0 == ASC_Q) begin
      echo_byte = s_r.idle ? ASC_O : ASC_C;
    end else begin
      echo_byte = s_r.b0;
    end

    // Pop the head into the transmit strobe.
    if (buf_out_valid && buf_out_ready) begin
      s_nxt.mtx  = echo_byte;
      s_nxt.mwr  = 1'b1;
      s_nxt.b0   = s_r.b1;
      s_nxt.bvld = {1'b0, s_r.bvld[1]};
    end
    // Push a received byte behind whatever remains.
    if (buf_in_valid && (buf_in_ready || (buf_out_valid && buf_out_ready))) begin
      s_nxt.mrd = 1'b1;
      if (!s_nxt.bvld[0]) begin
        s_nxt.b0      = mon_rx_data;
        s_nxt.bvld[0] = 1'b1;
      end else begin
        s_nxt.b1      = mon_rx_data;
        s_nxt.bvld[1] = 1'b1;
      end
    end

    // Controller activity.
    case (s_r.st)
      ST_IDLE: begin
        if (inject_req && s_r.idle) begin
          s_nxt.param   = inject_param;
          s_nxt.flip    = 1'b1;
          s_nxt.busy    = 1'b1;
          s_nxt.inj_cnt = INJ_BUSY_CYC;
          s_nxt.st      = ST_INJECT;
        end else if (fetch_req && (status_correct || status_classify)) begin
          s_nxt.tx_idx = 3'h0;
          s_nxt.st     = ST_FETCH_TX;
        end
      end
      ST_INJECT: begin
        s_nxt.inj_cnt = s_r.inj_cnt - 4'h1;
        if (s_r.inj_cnt == 4'h1) begin
          s_nxt.busy = 1'b0;
          s_nxt.st   = ST_IDLE;
        end
      end
      ST_FETCH_TX: begin
        // Kind byte, then base address most significant byte first.
        if (!fetch_tx_full && !s_r.fwr) begin
          s_nxt.fwr = 1'b1;
          case (s_r.tx_idx)
            3'h0:    s_nxt.ftx = fetch_essential ? FETCH_ESS_FRAME
                                                 : FETCH_CFG_FRAME;
            3'h1:    s_nxt.ftx = fetch_table_base[31:24];
            3'h2:    s_nxt.ftx = fetch_table_base[23:16];
            3'h3:    s_nxt.ftx = fetch_table_base[15:8];
            default: s_nxt.ftx = fetch_table_base[7:0];
          endcase
          s_nxt.tx_idx = s_r.tx_idx + 3'h1;
          if (s_r.tx_idx == FETCH_CMD_LEN - 3'h1) begin
            s_nxt.rx_cnt = FETCH_RX_LEN;
            s_nxt.st     = ST_FETCH_RX;
          end
        end
      end
      ST_FETCH_RX: begin
        // Reply bytes are shifted in, first byte most significant.
        if (!fetch_rx_empty && !s_r.frd) begin
          s_nxt.frd     = 1'b1;
          s_nxt.rx_word = {s_r.rx_word[ADDR_W-BYTE_W-1:0], fetch_rx_data};
          s_nxt.rx_cnt  = s_r.rx_cnt - 8'h01;
          if (s_r.rx_cnt == 8'h01) begin
            s_nxt.st = ST_IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Idle is all five state indications low with no fetch under way. It is taken from the next
    // state, so that it falls in the very cycle in which busy rises.
    s_nxt.idle = (s_nxt.st == ST_IDLE) && !s_nxt.busy && !status_init
                 && !status_observe && !status_correct && !status_classify;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  // Registers the state record; reset clears everything.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.
  // Each strobe is a register bit that the next-state logic clears by default,
  // so no strobe can stand for more than one cycle.
  // Holding the outputs in flip-flops keeps the far side free of glitches.

  assign mon_tx_data    = s_r.mtx;
  assign mon_tx_write   = s_r.mwr;
  assign mon_rx_read    = s_r.mrd;
  assign fetch_tx_data  = s_r.ftx;
  assign fetch_tx_write = s_r.fwr;
  assign fetch_rx_read  = s_r.frd;
  assign inject_busy    = s_r.busy;
  assign flip_strobe    = s_r.flip;
  assign flip_param     = s_r.param;
  assign ctl_idle       = s_r.idle;
  assign fetch_word     = s_r.rx_word;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  // The parameter bus is taken in the cycle of an accepted request.
  chk_inject_capture: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == ST_IDLE && inject_req && s_r.idle) |=> (flip_param == $past(inject_param)))
    else $error("Injection parameter not captured with request.");

  // An accepted request gives the flip command and raises busy.
  chk_inject_busy: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == ST_IDLE && inject_req && s_r.idle) |=> (flip_strobe && inject_busy))
    else $error("Accepted injection did not flip and raise busy.");

  // Busy stands for exactly eight cycles, then drops.
  chk_busy_ends: assert property (@(posedge clk) disable iff (rst)
    $rose(inject_busy) |-> inject_busy [*8] ##1 !inject_busy)
    else $error("Injection busy length wrong.");

  // A full console channel holds off the next write.
  chk_mon_full: assert property (@(posedge clk) disable iff (rst)
    mon_tx_full |=> !mon_tx_write)
    else $error("Console write while full.");

  // A full fetch channel holds off the next write.
  chk_fetch_full: assert property (@(posedge clk) disable iff (rst)
    fetch_tx_full |=> !fetch_tx_write)
    else $error("Fetch write while full.");

  // Write strobes last one cycle on both outbound channels.
  chk_strobe_single: assert property (@(posedge clk) disable iff (rst)
    (mon_tx_write |=> !mon_tx_write) and (fetch_tx_write |=> !fetch_tx_write))
    else $error("Write strobe longer than one cycle.");

  // No read strobe follows a cycle in which the channel was empty.
  chk_rx_empty: assert property (@(posedge clk) disable iff (rst)
    (mon_rx_empty |=> !mon_rx_read) and (fetch_rx_empty |=> !fetch_rx_read))
    else $error("Read strobe while empty.");

  // The first command byte names the kind of frame wanted.
  chk_fetch_kind: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == ST_FETCH_TX && s_r.tx_idx == 3'h0 && !fetch_tx_full && !s_r.fwr)
    |=> (fetch_tx_data == ($past(fetch_essential) ? FETCH_ESS_FRAME : FETCH_CFG_FRAME)))
    else $error("Fetch command kind byte wrong.");

  // Any high state indication clears idle in the next cycle.
  chk_idle_decode: assert property (@(posedge clk) disable iff (rst)
    (status_init || status_observe || status_correct || status_classify) |=> !ctl_idle)
    else $error("Idle shown while a state indication is high.");

  // Idle never stands together with the injection indication.
  chk_idle_busy: assert property (@(posedge clk) disable iff (rst)
    inject_busy |-> !ctl_idle)
    else $error("Idle shown while injection is in progress.");

  // The flip command lasts one cycle and comes with busy.
  chk_flip_single: assert property (@(posedge clk) disable iff (rst)
    flip_strobe |-> inject_busy ##1 !flip_strobe)
    else $error("Bit-flip command longer than one cycle.");

  // Read strobes last one cycle on both inbound channels.
  chk_read_single: assert property (@(posedge clk) disable iff (rst)
    (mon_rx_read |=> !mon_rx_read) and (fetch_rx_read |=> !fetch_rx_read))
    else $error("Read strobe longer than one cycle.");

  // A request made while not idle is ignored.
  chk_inject_refused: assert property (@(posedge clk) disable iff (rst)
    (inject_req && !ctl_idle) |=> !flip_strobe)
    else $error("Injection accepted while not idle.");

endmodule

/* bench/far_side_model.sv */
module far_side_model
  import cmd_port_pkg::*;
(
  // Clock and reset.
  input  wire logic                            clk,
  input  wire logic                            rst,
  // Console channel pair.
  input  wire logic [cmd_port_pkg::BYTE_W-1:0] mon_tx_data,
  input  wire logic                            mon_tx_write,
  output logic                                 mon_tx_full,
  output logic      [cmd_port_pkg::BYTE_W-1:0] mon_rx_data,
  input  wire logic                            mon_rx_read,
  output logic                                 mon_rx_empty,
  // Fetch channel pair.
  input  wire logic [cmd_port_pkg::BYTE_W-1:0] fetch_tx_data,
  input  wire logic                            fetch_tx_write,
  output logic                                 fetch_tx_full,
  output logic      [cmd_port_pkg::BYTE_W-1:0] fetch_rx_data,
  input  wire logic                            fetch_rx_read,
  output logic                                 fetch_rx_empty
);
  timeunit 1ns;
  timeprecision 1ps;
  // Queues: console in and out, fetch commands, pending and visible replies.
  logic [7:0] rx_q[$], tx_q[$], fcmd[$], pend[$], frx[$];
  // Knobs set by the bench, and last strobes for spacing checks.
  logic       mon_stall = 0, fetch_stall = 0, slow = 0, tick = 0, mw_d = 0, fw_d = 0;
  logic [7:0] mon_last = 8'h00, fet_last = 8'h00;
  int         viol = 0;
  // Strobes are taken at the edge; new levels appear just after it.
  always @(posedge clk) begin
    if (!rst && ((mon_tx_write && (mon_tx_full || mw_d)) || (fetch_tx_write && (fetch_tx_full || fw_d))))
      viol++;
    if (!rst && ((mon_rx_read && mon_rx_empty) || (fetch_rx_read && fetch_rx_empty)))
      viol++;
    mw_d = mon_tx_write;
    fw_d = fetch_tx_write;
    if (mon_tx_write)
      tx_q.push_back(mon_tx_data);
    if (mon_rx_read && !mon_rx_empty)
      mon_last = rx_q.pop_front();
    if (fetch_rx_read && !fetch_rx_empty)
      fet_last = frx.pop_front();
    if (fetch_tx_write) begin
      fcmd.push_back(fetch_tx_data);
      // A whole command is answered with four bytes derived from it.
      if (fcmd.size() == 5)
        for (int i = 1; i < 5; i++)
          pend.push_back(fcmd[i] ^ fcmd[0]);
    end
    tick = ~tick;
    // A slow source releases one reply byte every other cycle.
    if (pend.size() > 0 && (!slow || tick))
      frx.push_back(pend.pop_front());
    #1;
    mon_tx_full = mon_stall;
    fetch_tx_full = fetch_stall;
    mon_rx_empty = (rx_q.size() == 0);
    fetch_rx_empty = (frx.size() == 0);
    // A released data line shows the inverse of its last byte.
    mon_rx_data = mon_rx_empty ? ~mon_last : rx_q[0];
    fetch_rx_data = fetch_rx_empty ? ~fet_last : frx[0];
  end
endmodule

/* bench/testbench.sv */
module testbench
  import cmd_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus and results of the block.
  logic              clk, rst, inject_req, fetch_req, fetch_essential, inject_busy, flip_strobe;
  logic              status_correct, status_classify, status_init, status_observe, ctl_idle;
  logic [INJ_W-1:0]  inject_param, flip_param;
  logic [ADDR_W-1:0] fetch_table_base, fetch_word;
  // Channel wires between the block and the far side.
  logic [BYTE_W-1:0] mon_tx_data, mon_rx_data, fetch_tx_data, fetch_rx_data;
  logic              mon_tx_write, mon_tx_full, mon_rx_read, mon_rx_empty;
  logic              fetch_tx_write, fetch_tx_full, fetch_rx_read, fetch_rx_empty;
  int                error_cnt = 0;
  int                checked = 0;

  cmd_ports dut (
    .clk(clk), .rst(rst), .inject_req(inject_req), .inject_param(inject_param),
    .fetch_req(fetch_req), .fetch_essential(fetch_essential),
    .status_correct(status_correct), .status_classify(status_classify),
    .status_init(status_init), .status_observe(status_observe),
    .mon_tx_data(mon_tx_data), .mon_tx_write(mon_tx_write), .mon_tx_full(mon_tx_full),
    .mon_rx_data(mon_rx_data), .mon_rx_read(mon_rx_read), .mon_rx_empty(mon_rx_empty),
    .fetch_tx_data(fetch_tx_data), .fetch_tx_write(fetch_tx_write),
    .fetch_tx_full(fetch_tx_full), .fetch_rx_data(fetch_rx_data),
    .fetch_rx_read(fetch_rx_read), .fetch_rx_empty(fetch_rx_empty),
    .fetch_table_base(fetch_table_base), .inject_busy(inject_busy),
    .flip_strobe(flip_strobe), .flip_param(flip_param), .ctl_idle(ctl_idle),
    .fetch_word(fetch_word)
  );
  far_side_model far (
    .clk(clk), .rst(rst),
    .mon_tx_data(mon_tx_data), .mon_tx_write(mon_tx_write), .mon_tx_full(mon_tx_full),
    .mon_rx_data(mon_rx_data), .mon_rx_read(mon_rx_read), .mon_rx_empty(mon_rx_empty),
    .fetch_tx_data(fetch_tx_data), .fetch_tx_write(fetch_tx_write),
    .fetch_tx_full(fetch_tx_full), .fetch_rx_data(fetch_rx_data),
    .fetch_rx_read(fetch_rx_read), .fetch_rx_empty(fetch_rx_empty)
  );

  // Free-running clock.
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Moves n edges on and lands just after the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait: 0 idle, 1 n console bytes out, 2 fetch finished.
  task automatic wait_for(input int w, input int n);
    for (int i = 0; i < 200; i++) begin
      if (w == 0 ? ctl_idle === 1'b1 : w == 1 ? far.tx_q.size() >= n :
          far.fcmd.size() >= 5 && far.frx.size() == 0 && far.pend.size() == 0)
        return;
      cyc(1);
    end
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    status_init = 1;
    cyc(4);
    check(ctl_idle, 0);
    status_init = 0;
    wait_for(0, 0);
    check(ctl_idle, 1);
  endtask
  // One injection, with a refused request made while busy.
  task automatic t_inject(input logic [39:0] p);
    inject_param = p;
    inject_req = 1;
    cyc(1);
    inject_req = 0;
    inject_param = ~p;
    check({flip_strobe, inject_busy, ctl_idle}, 3'b110);
    check(flip_param, p);
    for (int i = 0; i < 7; i++) begin
      inject_req = (i == 2);
      cyc(1);
      check({flip_strobe, inject_busy}, 2'b01);
    end
    cyc(1);
    check(inject_busy, 0);
    wait_for(0, 0);
    cyc(1);
    check(flip_strobe, 0);
  endtask
  task automatic t_console();
    far.mon_stall = 1;
    cyc(2);
    far.rx_q.push_back(8'h41);
    far.rx_q.push_back(ASC_CR);
    cyc(12);
    check(far.tx_q.size(), 0);
    check(far.rx_q.size(), 0);
    far.mon_stall = 0;
    wait_for(1, 2);
    check(far.tx_q[0], 8'h41);
    check(far.tx_q[1], ASC_O);
    status_observe = 1;
    far.rx_q.push_back(ASC_Q);
    wait_for(1, 3);
    check(far.tx_q[2], ASC_C);
    status_observe = 0;
    wait_for(0, 0);
    far.rx_q.push_back(ASC_CR);
    t_inject(40'h00_0000_0001);
    wait_for(1, 4);
    check(far.tx_q[3], ASC_I);
  endtask
  // One fetch of either kind, stalled by full or answered slowly.
  task automatic t_fetch(input logic ess, input logic stall);
    logic [7:0] kind;
    kind = ess ? FETCH_ESS_FRAME : FETCH_CFG_FRAME;
    far.fcmd.delete();
    far.fetch_stall = stall;
    far.slow = ~stall;
    cyc(2);
    {status_correct, status_classify} = {~ess, ess};
    fetch_essential = ess;
    fetch_req = 1;
    cyc(1);
    fetch_req = 0;
    cyc(10);
    check(far.fcmd.size(), stall ? 0 : 5);
    far.fetch_stall = 0;
    wait_for(2, 0);
    cyc(4);
    check(far.fcmd[0], kind);
    for (int i = 1; i < 5; i++)
      check(far.fcmd[i], fetch_table_base[32-8*i +: 8]);
    check(fetch_word, fetch_table_base ^ {4{kind}});
    {status_correct, status_classify} = 2'b00;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1;
    {inject_req, fetch_req, fetch_essential, status_correct} = '0;
    {status_classify, status_init, status_observe} = '0;
    inject_param = '0;
    fetch_table_base = 32'hA5C3_1E97;
    repeat (5) @(posedge clk);
    #1;
    check({inject_busy, flip_strobe, mon_tx_write, fetch_tx_write, ctl_idle}, 0);
    rst = 0;
    t_idle();
    t_inject(40'h12_3456_789A);
    t_inject(40'hED_CBA9_8765);
    t_console();
    t_fetch(1'b0, 1'b1);
    t_fetch(1'b1, 1'b0);
    check(far.viol, 0);
    end_sim();
  end
endmodule
